// ===== core/commutation_guard.sv
// three-phase commutation decoder with direction latch and dead-time guard
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module commutation_guard #(
  parameter int tach_cycles = commutation_pkg::tach_pulse_cycles,
  parameter int osc_half = commutation_pkg::osc_half_cycles
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // motor side inputs
  input wire logic position_sensor_first,
  input wire logic position_sensor_second,
  input wire logic position_sensor_third,
  input wire logic dir_in,
  input wire logic speed_fast,
  input wire logic brake_req,
  input wire logic coast_req,
  input wire logic full_chop,
  input wire logic pwm_on,
  // power stage and tach
  output commutation_pkg::bridge_s gates,
  output logic tach_pulse
);

  // ****************************************************************
  // registers and synchronisers
  // ****************************************************************
  logic [5:0] ctrl_r;
  logic [31:0] tach_cfg_r;
  logic [31:0] osc_cfg_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [2:0] pos_r;
  logic [2:0] pos_prev_r;
  logic dlatch_r;
  logic stage1_r;
  logic stage2_r;
  logic [31:0] osc_cnt_r;
  logic osc_tick;
  logic [31:0] tach_cnt_r;
  logic init_r;
  logic ack_r;

  // effective controls: pins or software override
  logic dir_eff;
  logic fast_eff;
  logic brake_eff;
  logic coast_eff;
  logic full_eff;
  logic mismatch;
  commutation_pkg::bridge_s gates_nxt;

  // decode one phase state into switch gates
  function automatic commutation_pkg::gate_s phase_gate(
    input commutation_pkg::phase_e st,
    input logic pwm,
    input logic full
  );
    commutation_pkg::gate_s g;
    g.hi = (st == commutation_pkg::ph_source) && (pwm || !full);
    g.lo = (st == commutation_pkg::ph_sink) && pwm;
    return g;
  endfunction : phase_gate

  // sensor code plus direction to per-phase states a,b,c
  function automatic logic [5:0] decode(input logic dir, input logic [2:0] code);
    logic [5:0] r;
    r = {commutation_pkg::ph_off, commutation_pkg::ph_off, commutation_pkg::ph_off};
    if (dir)
    begin
      case (code)
        3'h1: r = {commutation_pkg::ph_off, commutation_pkg::ph_sink,
                   commutation_pkg::ph_source};
        3'h3: r = {commutation_pkg::ph_sink, commutation_pkg::ph_off,
                   commutation_pkg::ph_source};
        3'h2: r = {commutation_pkg::ph_sink, commutation_pkg::ph_source,
                   commutation_pkg::ph_off};
        3'h6: r = {commutation_pkg::ph_off, commutation_pkg::ph_source,
                   commutation_pkg::ph_sink};
        3'h4: r = {commutation_pkg::ph_source, commutation_pkg::ph_off,
                   commutation_pkg::ph_sink};
        3'h5: r = {commutation_pkg::ph_source, commutation_pkg::ph_sink,
                   commutation_pkg::ph_off};
        default: r = 6'h00;
      endcase
    end
    else
    begin
      case (code)
        3'h5: r = {commutation_pkg::ph_sink, commutation_pkg::ph_source,
                   commutation_pkg::ph_off};
        3'h4: r = {commutation_pkg::ph_sink, commutation_pkg::ph_off,
                   commutation_pkg::ph_source};
        3'h6: r = {commutation_pkg::ph_off, commutation_pkg::ph_sink,
                   commutation_pkg::ph_source};
        3'h2: r = {commutation_pkg::ph_source, commutation_pkg::ph_sink,
                   commutation_pkg::ph_off};
        3'h3: r = {commutation_pkg::ph_source, commutation_pkg::ph_off,
                   commutation_pkg::ph_sink};
        3'h1: r = {commutation_pkg::ph_off, commutation_pkg::ph_source,
                   commutation_pkg::ph_sink};
        default: r = 6'h00;
      endcase
    end
    return r;
  endfunction : decode

  // ****************************************************************
  // bus slave
  // ****************************************************************

  // one wait cycle per access, then acknowledge; waitrequest is its own flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      waitrequest <= 1'b1;
    end
    else if (clk_en)
    begin
      ack_r <= (read || write) && !ack_r;
      waitrequest <= !((read || write) && !ack_r);
    end
  end

  // register writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_r <= commutation_pkg::ctrl_reset_val;
      tach_cfg_r <= 32'(tach_cycles);
      osc_cfg_r <= 32'(osc_half);
    end
    else if (clk_en && write && ack_r)
    begin
      case (address)
        commutation_pkg::ctrl_off: ctrl_r <= writedata[5:0];
        commutation_pkg::tach_cfg_off: tach_cfg_r <= (writedata == 32'h0) ? 32'h1 : writedata;
        commutation_pkg::osc_cfg_off: osc_cfg_r <= (writedata == 32'h0) ? 32'h1 : writedata;
        default: ;
      endcase
    end
  end

  // register reads, unmapped read as zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      readdata <= 32'h0;
    else if (clk_en && read && !ack_r)
    begin
      case (address)
        commutation_pkg::ctrl_off: readdata <= {26'h0, ctrl_r};
        commutation_pkg::status_off:
          readdata <= {24'h0, tach_pulse, mismatch, stage2_r, stage1_r, dlatch_r, pos_r};
        commutation_pkg::tach_cfg_off: readdata <= tach_cfg_r;
        commutation_pkg::osc_cfg_off: readdata <= osc_cfg_r;
        default: readdata <= 32'h0;
      endcase
    end
  end

  // control source: pins, or software when selected
  always_comb
  begin
    if (ctrl_r[commutation_pkg::ctrl_sel_sw_bit])
    begin
      dir_eff = ctrl_r[commutation_pkg::ctrl_dir_bit];
      fast_eff = ctrl_r[commutation_pkg::ctrl_fast_bit];
      brake_eff = ctrl_r[commutation_pkg::ctrl_brake_bit];
      coast_eff = ctrl_r[commutation_pkg::ctrl_coast_bit];
      full_eff = ctrl_r[commutation_pkg::ctrl_full_chop_bit];
    end
    else
    begin
      dir_eff = sync2_r[3];
      fast_eff = speed_fast;
      brake_eff = brake_req;
      coast_eff = coast_req;
      full_eff = full_chop;
    end
  end

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // kept running through reset so the init cycle sees real pin levels
  always_ff @(posedge ref_clk)
  begin
    if (clk_en)
    begin
      sync1_r <= {dir_in, position_sensor_first, position_sensor_second,
                  position_sensor_third};
      sync2_r <= sync1_r;
    end
  end

  // ****************************************************************
  // position latch and tach pulse
  // ****************************************************************

  // positions follow sensors unless tach pulse holds them
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pos_r <= 3'h0;
      pos_prev_r <= 3'h0;
      tach_cnt_r <= 32'h0;
      tach_pulse <= 1'b0;
      init_r <= 1'b1;
    end
    else if (clk_en)
    begin
      init_r <= 1'b0;
      if (!tach_pulse)
        pos_r <= sync2_r[2:0];
      pos_prev_r <= sync2_r[2:0];
      if (tach_pulse)
      begin
        if (tach_cnt_r <= 32'h1)
          tach_pulse <= 1'b0;
        tach_cnt_r <= tach_cnt_r - 32'h1;
      end
      else if (!init_r && sync2_r[2:0] != pos_prev_r)
      begin
        tach_pulse <= 1'b1;
        tach_cnt_r <= tach_cfg_r;
      end
    end
  end

  // ****************************************************************
  // pwm oscillator tick
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      osc_cnt_r <= 32'h0;
    else if (clk_en)
      osc_cnt_r <= osc_tick ? 32'h0 : osc_cnt_r + 32'h1;
  end

  assign osc_tick = (osc_cnt_r >= (osc_cfg_r << 1) - 32'h1);

  // ****************************************************************
  // direction latch and shift register
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dlatch_r <= 1'b0;
    else if (clk_en)
    begin
      if (init_r)
        dlatch_r <= dir_eff;
      else if (!fast_eff)
        dlatch_r <= dir_eff;
      // fast: hold value, below
    end
  end

  // stages step on oscillator ticks only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (init_r)
      begin
        stage1_r <= dir_eff;
        stage2_r <= dir_eff;
      end
      else if (osc_tick)
      begin
        stage1_r <= dlatch_r;
        stage2_r <= stage1_r;
      end
    end
  end

  // latch holds while fast, so its mismatch blanks until slow again or until the direction returns to the latched value
  assign mismatch = (dir_eff != dlatch_r) || (dlatch_r != stage1_r)
                    || (stage1_r != stage2_r);

  // ****************************************************************
  // output drive
  // ****************************************************************
  always_comb
  begin
    logic [5:0] st;
    st = decode(stage2_r, pos_r);
    gates_nxt.a = phase_gate(commutation_pkg::phase_e'(st[5:4]), pwm_on, full_eff);
    gates_nxt.b = phase_gate(commutation_pkg::phase_e'(st[3:2]), pwm_on, full_eff);
    gates_nxt.c = phase_gate(commutation_pkg::phase_e'(st[1:0]), pwm_on, full_eff);
    if (coast_eff || mismatch || init_r)
      gates_nxt = '0;
    else if (brake_eff)
      gates_nxt = {1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      gates <= '0;
    else if (clk_en)
      gates <= gates_nxt;
  end

endmodule : commutation_guard

// ===== inc/commutation_pkg.sv
// shared constants and carriers for the commutation guard
package commutation_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] status_off = 4'h4;
  localparam logic [3:0] tach_cfg_off = 4'h8;
  localparam logic [3:0] osc_cfg_off = 4'hC;

  // ctrl register fields
  localparam int ctrl_dir_bit = 0;
  localparam int ctrl_brake_bit = 1;
  localparam int ctrl_coast_bit = 2;
  localparam int ctrl_full_chop_bit = 3;
  localparam int ctrl_fast_bit = 4;
  localparam int ctrl_sel_sw_bit = 5;
  localparam logic [5:0] ctrl_reset_val = 6'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int clk_mhz = 250;
  localparam int tach_pulse_ns = 113000;
  localparam int tach_pulse_cycles = (tach_pulse_ns * clk_mhz + 999) / 1000;
  localparam int osc_hz = 20000;
  localparam int osc_half_cycles = (clk_mhz * 1000000) / (2 * osc_hz);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0]
  {
    ph_off = 2'b00,
    ph_sink = 2'b01,
    ph_source = 2'b10
  } phase_e;

  // one phase: high and low switch gates, both low is high impedance
  typedef struct packed
  {
    logic hi;
    logic lo;
  } gate_s;

  typedef struct packed
  {
    gate_s a;
    gate_s b;
    gate_s c;
  } bridge_s;

endpackage : commutation_pkg

// ===== test/guard_checker_asserts.sv
// port-level assertions for the commutation guard
`timescale 1ns/1ps

module guard_checker_asserts #(
  parameter int tach_cycles = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // motor side
  input wire logic position_sensor_first,
  input wire logic position_sensor_second,
  input wire logic position_sensor_third,
  input wire logic dir_in,
  input wire logic speed_fast,
  input wire logic brake_req,
  input wire logic coast_req,
  input wire commutation_pkg::bridge_s gates,
  input wire logic tach_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [2:0] code;
  int tach_len_r;
  // sensor code, first sensor as msb
  assign code = {position_sensor_first, position_sensor_second, position_sensor_third};
  // counts the cycles of the current tach pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst || !tach_pulse)
      tach_len_r <= 0;
    else
      tach_len_r <= tach_len_r + 1;
  end
  sequence dir_flip;
    $changed(dir_in) && !speed_fast && clk_en;
  endsequence
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_no_shoot_through: assert property ((gates.a.hi & gates.a.lo) == 1'h0 &&
    (gates.b.hi & gates.b.lo) == 1'h0 && (gates.c.hi & gates.c.lo) == 1'h0)
    else $error("phase drives both switches");
  a_coast_floats: assert property ((coast_req && clk_en) [*5] |-> gates == 6'h00)
    else $error("coast left a phase driven");
  a_brake_highs_off: assert property ((brake_req && clk_en) [*5] |->
    !gates.a.hi && !gates.b.hi && !gates.c.hi)
    else $error("brake left a high switch on");
  a_illegal_code: assert property ((code inside {3'h0, 3'h7} && !tach_pulse) [*6] |->
    gates == 6'h00)
    else $error("illegal sensor code drove a phase");
  a_tach_width: assert property ($fell(tach_pulse) |-> tach_len_r == tach_cycles)
    else $error("tach pulse width wrong");
  a_tach_start: assert property ($changed(code) && !tach_pulse ##1 !tach_pulse |->
    ##[1:3] tach_pulse)
    else $error("sensor change gave no tach pulse");
  a_dir_blank: assert property (dir_flip |-> ##5 (gates == 6'h00) [*4])
    else $error("direction change not blanked");
  a_bus_one_wait: assert property ($rose(read || write) |-> one_wait)
    else $error("bus answer not after one wait state");
endmodule : guard_checker_asserts

bind commutation_guard guard_checker_asserts #(.tach_cycles(tach_cycles)) chk (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .read(read), .write(write),
  .waitrequest(waitrequest), .position_sensor_first(position_sensor_first),
  .position_sensor_second(position_sensor_second),
  .position_sensor_third(position_sensor_third), .dir_in(dir_in), .speed_fast(speed_fast),
  .brake_req(brake_req), .coast_req(coast_req), .gates(gates), .tach_pulse(tach_pulse));

// ===== test/hall_sensor_model.sv
// position sensor model: gray sequence or a forced code
`timescale 1ns/1ps

module hall_sensor_model (
  // clock and control
  input wire logic ref_clk,
  input wire logic step,
  input wire logic fwd,
  input wire logic force_en,
  input wire logic [2:0] force_code,
  // sensor code, first sensor as msb
  output logic [2:0] code
);
  localparam logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int idx_r = 0;
  // one sensor changes per step, either direction
  always @(posedge ref_clk)
  begin
    if (step)
      idx_r <= fwd ? (idx_r + 1) % 6 : (idx_r + 5) % 6;
  end
  // sensors spaced at 120 degrees need no inversion
  assign code = force_en ? force_code : seq[idx_r];
endmodule : hall_sensor_model

// ===== test/test_commutation_guard.sv
// self-checking bench for the commutation guard
`timescale 1ns/1ps

module test_commutation_guard;
  logic ref_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, read = 1'h0, write = 1'h0;
  logic waitrequest, tach_pulse, step = 1'h0, force_en = 1'h0;
  logic dir_in = 1'h0, speed_fast = 1'h0, brake_req = 1'h0, coast_req = 1'h0;
  logic full_chop = 1'h0, pwm_on = 1'h1;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [2:0] force_code = 3'h0, code;
  commutation_pkg::bridge_s gates;
  int fail_count = 0, total_checks = 0, cycles = 0;
  localparam logic [5:0] fwd_tab [8] = '{6'h00, 6'h06, 6'h18, 6'h12, 6'h21, 6'h24, 6'h09, 6'h00};
  // design and sensor model
  commutation_guard #(.tach_cycles(8), .osc_half(4)) uut (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .position_sensor_first(code[2]),
    .position_sensor_second(code[1]), .position_sensor_third(code[0]), .dir_in(dir_in),
    .speed_fast(speed_fast), .brake_req(brake_req), .coast_req(coast_req),
    .full_chop(full_chop), .pwm_on(pwm_on), .gates(gates), .tach_pulse(tach_pulse));
  hall_sensor_model sens (.ref_clk(ref_clk), .step(step), .fwd(dir_in), .force_en(force_en),
    .force_code(force_code), .code(code));
  // clock and hang limit
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic check6(input logic [5:0] got, input logic [5:0] want);
    total_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("unexpected at %0t gates %h want %h", $time, got, want);
    end
  endtask : check6
  task automatic check32(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("unexpected at %0t data %h want %h", $time, got, want);
    end
  endtask : check32
  // expected gates with pwm conducting; reverse swaps source and sink
  function automatic logic [5:0] exp_g(input logic d, input logic [2:0] c);
    logic [5:0] e;
    e = fwd_tab[c];
    return d ? e : {e[4], e[5], e[2], e[3], e[0], e[1]};
  endfunction : exp_g
  // one bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    do @(posedge ref_clk); while (waitrequest !== 1'h0);
    rd = readdata;
    write <= 1'h0;
    read <= 1'h0;
  endtask : bus
  task automatic pulse_step;
    @(posedge ref_clk);
    step <= 1'h1;
    @(posedge ref_clk);
    step <= 1'h0;
  endtask : pulse_step
  task automatic t_reset(input logic d);
    @(posedge ref_clk);
    rst <= 1'h1;
    dir_in <= d;
    tick(6);
    rst <= 1'h0;
    tick(12);
    check6(gates, exp_g(d, code));
  endtask : t_reset
  task automatic t_regs;
    bus(1'h1, 4'h8, 32'h8);
    bus(1'h1, 4'hC, 32'h4);
    bus(1'h1, 4'h2, 32'hFF);
    bus(1'h0, 4'h8, 32'h0);
    check32(rd, 32'h8);
    bus(1'h0, 4'hC, 32'h0);
    check32(rd, 32'h4);
    bus(1'h0, 4'h2, 32'h0);
    check32(rd, 32'h0);
    bus(1'h0, 4'h0, 32'h0);
    check32(rd, 32'h0);
  endtask : t_regs
  // software override of the pin controls, then back to pins
  task automatic t_soft;
    bus(1'h1, 4'h0, 32'h23);
    tick(4);
    check6(gates, 6'h15);
    bus(1'h1, 4'h0, 32'h25);
    bus(1'h0, 4'h0, 32'h0);
    check32(rd, 32'h25);
    tick(4);
    check6(gates, 6'h00);
    bus(1'h1, 4'h0, 32'h0);
    tick(4);
    check6(gates, exp_g(1'h1, code));
  endtask : t_soft
  task automatic t_table(input logic d);
    dir_in <= d;
    tick(40);
    repeat (6)
    begin
      pulse_step;
      tick(16);
      check6(gates, exp_g(d, code));
    end
  endtask : t_table
  task automatic t_illegal;
    for (int i = 0; i < 4; i++)
    begin
      force_en <= 1'h1;
      force_code <= i[0] ? 3'h7 : 3'h0;
      dir_in <= i[1];
      tick(40);
      check6(gates, 6'h00);
    end
    force_en <= 1'h0;
    dir_in <= 1'h1;
    tick(40);
  endtask : t_illegal
  task automatic t_hold;
    logic [2:0] first_code;
    pulse_step;
    tick(5);
    first_code = code;
    pulse_step;
    tick(5);
    check6(gates, exp_g(1'h1, first_code));
    tick(30);
    check6(gates, exp_g(1'h1, code));
  endtask : t_hold
  task automatic t_brake;
    clk_en <= 1'h0;
    brake_req <= 1'h1;
    tick(8);
    check6(gates, exp_g(1'h1, code));
    clk_en <= 1'h1;
    tick(8);
    check6(gates, 6'h15);
    coast_req <= 1'h1;
    tick(8);
    check6(gates, 6'h00);
    brake_req <= 1'h0;
    tick(8);
    check6(gates, 6'h00);
    coast_req <= 1'h0;
    tick(8);
    check6(gates, exp_g(1'h1, code));
  endtask : t_brake
  task automatic t_chop;
    pwm_on <= 1'h0;
    tick(8);
    check6(gates, exp_g(1'h1, code) & 6'h2A);
    full_chop <= 1'h1;
    tick(8);
    check6(gates, 6'h00);
    brake_req <= 1'h1;
    tick(8);
    check6(gates, 6'h15);
    brake_req <= 1'h0;
    pwm_on <= 1'h1;
    tick(8);
    check6(gates, exp_g(1'h1, code));
    full_chop <= 1'h0;
  endtask : t_chop
  task automatic t_fast;
    speed_fast <= 1'h1;
    tick(4);
    dir_in <= 1'h0;
    tick(40);
    check6(gates, 6'h00);
    bus(1'h0, 4'h4, 32'h0);
    check32(rd & 32'h78, 32'h78);
    dir_in <= 1'h1;
    tick(8);
    check6(gates, exp_g(1'h1, code));
    speed_fast <= 1'h0;
    tick(8);
    dir_in <= 1'h0;
    tick(12);
    check6(gates, 6'h00);
    tick(9);
    check6(gates, exp_g(1'h0, code));
  endtask : t_fast
  // main sequence
  initial
  begin
    t_reset(1'h1);
    t_regs;
    t_soft;
    t_table(1'h1);
    t_table(1'h0);
    t_illegal;
    t_hold;
    t_brake;
    t_chop;
    t_fast;
    t_reset(1'h1);
    wrap_up;
  end
endmodule : test_commutation_guard
